//--- uscl_core.sv
// usart command, status and loop-back logic with its serial engines
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - stripping suppresses transfer only; escape and sync detect flags still set
// - submode 00 independent; 01 echo when async, stripping when sync
// - local loop: tx line to receiver, dtr to dcd, rts to cts, tx clock
// - local loop: modem outputs and tx line held high, line inputs ignored
// - remote loop: received chars go to tx holding, sent on receive clock
// - remote loop: nothing to processor, errors still set, ready pins high
// - command bits 5 and 1 drive rts and dtr pins low when set
// - writing error clear flushes parity and overrun flags, and framing in async only
// - bit 3 forces break in async, escape before next char in sync
// - status bit 0 valid only when enabled, shows holding register free
// - tx ready set when enabled and empty, not in echo or remote
// - rx ready set on char transfer, cleared by read or disable
// - tx empty set after a finished char with nothing waiting, cleared on load
// - set-ready or carrier change also sets bit 2, cleared by status read
// - bit 3 parity error, or first escape in sync transparent without parity
// - overrun when new char lands before previous read
// - async bit 5 flags missing first stop bit
// - sync bit 5 on sync char, pair, or escape plus first sync
// - bit 5 clears on disable, error clear async, status read sync
// - status bits 6 and 7 show inverted carrier and set-ready inputs
// - error clear is a one-shot, never read back as set
module uscl_core (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_enable,
  input wire logic i_ce_n,
  input wire logic i_rw,
  input wire logic [1:0] i_addr,
  input wire logic [uscl_pkg::DATA_W-1:0] i_data,
  input wire logic i_tx_bit_clock,
  input wire logic i_rx_bit_clock,
  input wire logic i_rx_data,
  input wire logic i_cts_n,
  input wire logic i_dcd_n,
  input wire logic i_dsr_n,
  output logic [uscl_pkg::DATA_W-1:0] o_data,
  output logic o_data_oe,
  output logic o_tx_data,
  output logic o_rts_n,
  output logic o_dtr_n,
  output logic o_tx_holding_free_n,
  output logic o_rx_char_available_n,
  output logic o_tx_idle_or_line_change_n
);
  import uscl_pkg::*;

  function automatic logic [7:0] fit(input logic [7:0] v, input logic [3:0] n);
    fit = v & (FULL_MASK >> (CHAR_MAX - n));
  endfunction

  function automatic logic [7:0] align(input logic [7:0] v, input logic [3:0] n);
    align = v >> (CHAR_MAX - n);
  endfunction

  logic [PIN_W-1:0] meta_q, sync_q, prev_q;
  uscl_pins_t s, p;
  // every pin crosses two flops; the bus is slow enough for that
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      meta_q <= PIN_RST;
      sync_q <= PIN_RST;
      prev_q <= PIN_RST;
    end else if (i_enable) begin
      meta_q <= {i_ce_n, i_rw, i_addr, i_data, i_tx_bit_clock, i_rx_bit_clock, i_rx_data, i_cts_n, i_dcd_n, i_dsr_n};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end
  assign s = uscl_pins_t'(sync_q);
  assign p = uscl_pins_t'(prev_q);

  logic [7:0] mr_q, cr_q, rhr_q, thr_q;
  logic [7:0] syn_q [3];
  logic [1:0] syn_ptr_q;
  logic rd, wr, rd_rhr, rd_sr, wr_thr, wr_cr, err_clr;
  // reads act as the enable falls, writes as it rises with the held data
  assign rd = p.ce_n & ~s.ce_n & ~s.rw;
  assign wr = ~p.ce_n & s.ce_n & p.rw;
  assign rd_rhr = rd & (s.addr == ADDR_DATA);
  assign rd_sr = rd & (s.addr == ADDR_SR_SYN);
  assign wr_thr = wr & (p.addr == ADDR_DATA);
  assign wr_cr = wr & (p.addr == ADDR_CMD);
  assign err_clr = wr_cr & p.data[CR_ERR_CLR];

  logic [1:0] sub;
  logic sync_m, echo, strip, local_m, remote, rx_on, tx_on, par_on, transp;
  logic [3:0] len;
  assign sub = cr_q[CR_SUB+:2];
  assign sync_m = (mr_q[MR_FMT+:2] == 2'h0);
  assign echo = (sub == SUB_ECHO) & ~sync_m;
  assign strip = (sub == SUB_ECHO) & sync_m;
  assign local_m = (sub == SUB_LOCAL);
  assign remote = (sub == SUB_REMOTE);
  assign len = 4'(mr_q[MR_LEN+:2]) + CHAR_MIN;
  assign par_on = mr_q[MR_PAR_ON];
  assign transp = mr_q[MR_TRANSP];
  // rx enable ignored in local loop
  assign rx_on = local_m | cr_q[CR_RX_EN];
  // tx enable ignored in remote loop
  assign tx_on = echo | remote | cr_q[CR_TX_EN];

  logic tx_line_q, rxd_eff, dcd_n_eff, dsr_n_eff, cts_n_eff, t_edge, r_edge;
  // internal loops; outside line inputs ignored
  assign rxd_eff = local_m ? tx_line_q : s.rxd;
  assign dcd_n_eff = local_m ? ~cr_q[CR_DTR] : s.dcd_n;
  assign cts_n_eff = local_m ? ~cr_q[CR_RTS] : s.cts_n;
  assign dsr_n_eff = local_m | s.dsr_n;
  // receiver on tx clock in local loop; transmitter on rx clock in echo and remote loop
  assign r_edge = local_m ? (~p.tx_bit_clock & s.tx_bit_clock) : (~p.rx_bit_clock & s.rx_bit_clock);
  assign t_edge = (echo | remote) ? (p.rx_bit_clock & ~s.rx_bit_clock) : (p.tx_bit_clock & ~s.tx_bit_clock);

  // receiver
  uscl_rx_st_t rx_st_q;
  logic [7:0] rx_sh_q, rx_char_q, sh_in;
  logic [3:0] rx_cnt_q;
  logic rx_done_q, rx_pbit_q, rx_ferr_q, hunt_hit_q, rx_last;
  assign sh_in = {rxd_eff, rx_sh_q[7:1]};
  assign rx_last = (rx_cnt_q == len - 4'h1);
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rx_st_q <= RX_IDLE;
      rx_sh_q <= CHAR_RST;
      rx_char_q <= CHAR_RST;
      rx_cnt_q <= 4'h0;
      rx_done_q <= 1'b0;
      rx_pbit_q <= 1'b0;
      rx_ferr_q <= 1'b0;
      hunt_hit_q <= 1'b0;
    end else if (i_enable) begin
      rx_done_q <= 1'b0;
      hunt_hit_q <= 1'b0;
      if (!rx_on) begin
        // disable drops any partial character at once
        rx_st_q <= sync_m ? RX_HUNT : RX_IDLE;
        rx_cnt_q <= 4'h0;
      end else if (r_edge) begin
        case (rx_st_q)
          RX_IDLE: begin
            if (!rxd_eff) begin
              rx_st_q <= RX_DATA;
              rx_cnt_q <= 4'h0;
            end
          end
          RX_HUNT: begin
            rx_sh_q <= sh_in;
            rx_cnt_q <= 4'h0;
            if (align(sh_in, len) == fit(syn_q[FIRST_SYNC_CHAR_IX], len)) begin
              rx_st_q <= mr_q[MR_SINGLE] ? RX_DATA : RX_SYNC2;
              hunt_hit_q <= mr_q[MR_SINGLE];
            end
          end
          RX_SYNC2: begin
            rx_sh_q <= sh_in;
            rx_cnt_q <= rx_cnt_q + 4'h1;
            if (rx_last) begin
              rx_cnt_q <= 4'h0;
              hunt_hit_q <= (align(sh_in, len) == fit(syn_q[SYN2_IX], len));
              rx_st_q <= (align(sh_in, len) == fit(syn_q[SYN2_IX], len)) ? RX_DATA : RX_HUNT;
            end
          end
          RX_DATA: begin
            rx_sh_q <= sh_in;
            rx_cnt_q <= rx_cnt_q + 4'h1;
            if (rx_last) begin
              rx_cnt_q <= 4'h0;
              if (par_on) begin
                rx_st_q <= RX_PAR;
              end else if (sync_m) begin
                rx_char_q <= align(sh_in, len);
                rx_ferr_q <= 1'b0;
                rx_done_q <= 1'b1;
              end else begin
                rx_st_q <= RX_STOP;
              end
            end
          end
          RX_PAR: begin
            rx_pbit_q <= rxd_eff;
            rx_st_q <= sync_m ? RX_DATA : RX_STOP;
            if (sync_m) begin
              rx_char_q <= align(rx_sh_q, len);
              rx_ferr_q <= 1'b0;
              rx_done_q <= 1'b1;
            end
          end
          RX_STOP: begin
            // only the first stop bit is checked
            rx_ferr_q <= ~rxd_eff;
            rx_char_q <= align(rx_sh_q, len);
            rx_done_q <= 1'b1;
            rx_st_q <= RX_IDLE;
          end
          default: rx_st_q <= RX_IDLE;
        endcase
      end
    end
  end

  // character classification and stripping
  logic is_s1, is_s2, is_esc, prev_s1_q, prev_esc_q, perr, esc_det, syn_det, strip_it, to_rhr, to_thr;
  assign is_s1 = (rx_char_q == fit(syn_q[FIRST_SYNC_CHAR_IX], len));
  assign is_s2 = (rx_char_q == fit(syn_q[SYN2_IX], len));
  assign is_esc = (rx_char_q == fit(syn_q[ESC_IX], len));
  assign perr = par_on & (^rx_char_q ^ rx_pbit_q ^ ~mr_q[MR_PAR_EVEN]);
  // only the first of two escapes
  assign esc_det = sync_m & transp & ~par_on & is_esc & ~prev_esc_q;
  // sync detect in the data stream
  assign syn_det = sync_m & (transp ? (is_s1 & prev_esc_q) : (mr_q[MR_SINGLE] ? is_s1 : (is_s2 & prev_s1_q)));
  assign strip_it = strip & (transp ? ((is_esc & ~prev_esc_q) | (is_s1 & prev_esc_q)) :
                    (mr_q[MR_SINGLE] ? is_s1 : ((is_s1 & ~prev_s1_q) | (is_s2 & prev_s1_q))));
  // nothing reaches the processor in remote loop
  assign to_rhr = rx_done_q & ~remote & ~strip_it;
  // echo and remote loop refill the transmitter
  assign to_thr = rx_done_q & (echo | remote);

  logic rx_avail_q, par_q, ovr_q, frm_q, dschg_q, dcd_n_q, dsr_n_q, line_chg, thr_full_q;
  assign line_chg = (dcd_n_eff != dcd_n_q) | (dsr_n_eff != dsr_n_q);
  // status flags: a set always beats a clear in the same cycle
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rhr_q <= CHAR_RST;
      rx_avail_q <= 1'b0;
      par_q <= 1'b0;
      ovr_q <= 1'b0;
      frm_q <= 1'b0;
      dschg_q <= 1'b0;
      dcd_n_q <= 1'b1;
      dsr_n_q <= 1'b1;
      prev_s1_q <= 1'b0;
      prev_esc_q <= 1'b0;
    end else if (i_enable) begin
      dcd_n_q <= dcd_n_eff;
      dsr_n_q <= dsr_n_eff;
      if (rx_done_q) begin
        prev_s1_q <= is_s1 & ~prev_s1_q;
        prev_esc_q <= is_esc & ~prev_esc_q;
      end
      if (to_rhr) begin
        rhr_q <= rx_char_q;
      end
      // ready on transfer, dropped by read or disable
      rx_avail_q <= to_rhr | (rx_avail_q & ~rd_rhr & rx_on);
      ovr_q <= (rx_done_q & (to_rhr ? (rx_avail_q & ~rd_rhr) : (remote & thr_full_q))) | (ovr_q & ~err_clr & rx_on);
      par_q <= (rx_done_q & (perr | esc_det)) | (par_q & ~err_clr & rx_on);
      frm_q <= (rx_done_q & ((rx_ferr_q & ~sync_m) | syn_det)) | hunt_hit_q |
               (frm_q & rx_on & ~(err_clr & ~sync_m) & ~(rd_sr & sync_m));
      // line change while either side enabled
      dschg_q <= (line_chg & (cr_q[CR_TX_EN] | cr_q[CR_RX_EN])) | (dschg_q & ~rd_sr);
    end
  end

  // transmitter
  uscl_tx_st_t tx_st_q;
  logic [7:0] tx_sh_q, tx_pick;
  logic [3:0] tx_cnt_q;
  logic tx_par_q, esc_sent_q, tx_empty_q, tx_go, take, pick_esc, char_end, load_cpu, load, tx_last;
  assign load_cpu = wr_thr & ~(echo | remote);
  assign load = load_cpu | to_thr;
  assign tx_go = tx_on & (echo | remote | ~cts_n_eff);
  assign tx_last = (tx_cnt_q == len - 4'h1);
  assign take = t_edge & (tx_st_q == TX_IDLE) & thr_full_q & tx_go & (~cr_q[CR_BRK] | (sync_m & esc_sent_q));
  // escape goes out ahead of the waiting character
  assign pick_esc = ~take & thr_full_q & sync_m & cr_q[CR_BRK] & ~esc_sent_q;
  assign tx_pick = take ? thr_q : (pick_esc ? syn_q[ESC_IX] : syn_q[FIRST_SYNC_CHAR_IX]);
  assign char_end = t_edge & ((tx_st_q == TX_STOP) | (sync_m & ((tx_st_q == TX_PAR) |
                    ((tx_st_q == TX_DATA) & tx_last & ~par_on))));
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      thr_q <= CHAR_RST;
      thr_full_q <= 1'b0;
      tx_empty_q <= 1'b0;
    end else if (i_enable) begin
      if (load) begin
        thr_q <= to_thr ? rx_char_q : p.data;
      end
      thr_full_q <= load | (thr_full_q & ~take);
      // empty only after a finished character, fill included
      tx_empty_q <= (char_end & ~thr_full_q & ~load) | (tx_empty_q & ~load);
    end
  end
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      tx_st_q <= TX_IDLE;
      tx_line_q <= 1'b1;
      tx_sh_q <= CHAR_RST;
      tx_cnt_q <= 4'h0;
      tx_par_q <= 1'b0;
      esc_sent_q <= 1'b0;
    end else if (i_enable && t_edge) begin
      case (tx_st_q)
        TX_IDLE: begin
          if (~sync_m & cr_q[CR_BRK]) begin
            tx_line_q <= 1'b0;
            tx_st_q <= TX_BREAK;
          end else if (sync_m & tx_go) begin
            // sync never idles: fill with the first sync character
            tx_line_q <= tx_pick[0];
            tx_sh_q <= tx_pick >> 1;
            tx_cnt_q <= 4'h1;
            tx_par_q <= ^fit(tx_pick, len) ^ ~mr_q[MR_PAR_EVEN];
            esc_sent_q <= ~take & (esc_sent_q | pick_esc);
            tx_st_q <= TX_DATA;
          end else if (take) begin
            tx_line_q <= 1'b0;
            tx_sh_q <= thr_q;
            tx_cnt_q <= 4'h0;
            tx_par_q <= ^fit(thr_q, len) ^ ~mr_q[MR_PAR_EVEN];
            tx_st_q <= TX_DATA;
          end else begin
            tx_line_q <= 1'b1;
          end
        end
        TX_DATA: begin
          tx_line_q <= tx_sh_q[0];
          tx_sh_q <= tx_sh_q >> 1;
          tx_cnt_q <= tx_cnt_q + 4'h1;
          if (tx_last) begin
            tx_st_q <= par_on ? TX_PAR : (sync_m ? TX_IDLE : TX_STOP);
          end
        end
        TX_PAR: begin
          tx_line_q <= tx_par_q;
          tx_st_q <= sync_m ? TX_IDLE : TX_STOP;
        end
        TX_STOP: begin
          tx_line_q <= 1'b1;
          tx_st_q <= TX_IDLE;
        end
        TX_BREAK: begin
          // at least one mark bit after the break ends
          tx_line_q <= ~cr_q[CR_BRK];
          if (!cr_q[CR_BRK]) begin
            tx_st_q <= TX_STOP;
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  logic [7:0] sr;
  always_comb begin
    sr = 8'h00;
    sr[SR_TX_HOLDING_FREE] = cr_q[CR_TX_EN] & ~thr_full_q & ~(echo | remote);
    sr[SR_RX_CHAR_AVAILABLE] = rx_avail_q;
    sr[SR_TXEMT] = (tx_empty_q & tx_on & ~echo) | dschg_q;
    sr[SR_PAR] = par_q;
    sr[SR_OVR] = ovr_q;
    sr[SR_FRM] = frm_q;
    sr[SR_DCD] = ~dcd_n_eff;
    sr[SR_DSR] = ~dsr_n_eff;
  end

  // registers and read data
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      mr_q <= MODE_RST;
      cr_q <= CMD_RST;
      syn_q[FIRST_SYNC_CHAR_IX] <= CHAR_RST;
      syn_q[SYN2_IX] <= CHAR_RST;
      syn_q[ESC_IX] <= CHAR_RST;
      syn_ptr_q <= FIRST_SYNC_CHAR_IX;
      o_data <= CHAR_RST;
      o_data_oe <= 1'b0;
    end else if (i_enable) begin
      o_data_oe <= ~s.ce_n & ~s.rw;
      if (wr && p.addr == ADDR_MODE) begin
        mr_q <= p.data;
      end
      if (wr_cr) begin
        // error clear bit is not stored
        cr_q <= p.data & ~(8'h01 << CR_ERR_CLR);
      end
      if (wr && p.addr == ADDR_SR_SYN) begin
        syn_q[syn_ptr_q] <= p.data;
        syn_ptr_q <= (syn_ptr_q == ESC_IX) ? FIRST_SYNC_CHAR_IX : syn_ptr_q + 2'h1;
      end
      if (rd) begin
        case (s.addr)
          ADDR_DATA: o_data <= rhr_q;
          ADDR_SR_SYN: o_data <= sr;
          ADDR_MODE: o_data <= mr_q;
          default: o_data <= cr_q;
        endcase
      end
    end
  end

  // pins: ready and status outputs are active low
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_tx_data <= 1'b1;
      o_rts_n <= 1'b1;
      o_dtr_n <= 1'b1;
      o_tx_holding_free_n <= 1'b1;
      o_rx_char_available_n <= 1'b1;
      o_tx_idle_or_line_change_n <= 1'b1;
    end else if (i_enable) begin
      o_tx_data <= local_m | tx_line_q;
      o_rts_n <= local_m | ~cr_q[CR_RTS];
      o_dtr_n <= local_m | ~cr_q[CR_DTR];
      // held high in remote; holding free also held high in echo
      o_tx_holding_free_n <= echo | remote | ~sr[SR_TX_HOLDING_FREE];
      o_rx_char_available_n <= remote | ~sr[SR_RX_CHAR_AVAILABLE];
      o_tx_idle_or_line_change_n <= remote | ~sr[SR_TXEMT];
    end
  end
endmodule // uscl_core
`default_nettype wire

//--- uscl_core_bench.sv
// self-checking bench for the usart command/status block
`timescale 1ns/1ps
`default_nettype none
module uscl_core_bench;
  import uscl_pkg::*;
  typedef struct packed {
    logic [7:0] cmd;
    logic dcd_n;
    logic dsr_n;
    logic [2:0] pins_n;
    logic [1:0] st76;
  } uscl_row_t;
  // command, modem inputs, expected rts/dtr/holding-free pins, status bits 7:6
  localparam uscl_row_t ROWS [6] = '{'{8'h00, 1'h0, 1'h1, 3'h7, 2'h1}, '{8'h20, 1'h1, 1'h0, 3'h3, 2'h2},
    '{8'h02, 1'h1, 1'h1, 3'h5, 2'h0}, '{8'h22, 1'h0, 1'h0, 3'h1, 2'h3},
    '{8'hA3, 1'h1, 1'h0, 3'h6, 2'h1}, '{8'hE0, 1'h0, 1'h1, 3'h3, 2'h1}};
  logic i_clock;
  logic i_rst;
  logic run;
  uscl_pins_t pins;
  logic [7:0] data, q, q2;
  logic oe, txd, rts_n, dtr_n, hf_n, ra_n, te_n, tx_bit_clock, rx_bit_clock, rxd, ok;
  int n_errors, total_checks;
  uscl_core dut (.i_clock(i_clock), .i_rst(i_rst), .i_enable(1'h1), .i_ce_n(pins.ce_n), .i_rw(pins.rw),
    .i_addr(pins.addr), .i_data(pins.data), .i_tx_bit_clock(tx_bit_clock), .i_rx_bit_clock(rx_bit_clock), .i_rx_data(rxd),
    .i_cts_n(pins.cts_n), .i_dcd_n(pins.dcd_n), .i_dsr_n(pins.dsr_n), .o_data(data), .o_data_oe(oe),
    .o_tx_data(txd), .o_rts_n(rts_n), .o_dtr_n(dtr_n), .o_tx_holding_free_n(hf_n),
    .o_rx_char_available_n(ra_n), .o_tx_idle_or_line_change_n(te_n));
  uscl_line_model line (.i_run(run), .i_tx_data(txd), .o_txc(tx_bit_clock), .o_rxc(rx_bit_clock), .o_rxd(rxd));
  initial begin
    i_clock = 1'h0;
    forever #20 i_clock = ~i_clock;
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask
  task automatic wt(input logic c);
    if (!c) begin
      n_errors++;
      stop_test();
    end
  endtask
  // pins pass two sync stages, so hold everything well past the strobe
  task automatic bus(input logic w, input logic [1:0] a, input logic [7:0] d);
    @(negedge i_clock);
    pins.rw = w;
    pins.addr = a;
    pins.data = d;
    pins.ce_n = 1'h0;
    repeat (6) @(negedge i_clock);
    q = data;
    pins.ce_n = 1'h1;
    repeat (6) @(negedge i_clock);
  endtask
  task automatic rdm(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e);
    bus(1'h0, a, 8'h00);
    chk(q & m, e);
  endtask
  initial begin
    repeat (60000) @(posedge i_clock);
    n_errors++;
    stop_test();
  end
  initial begin
    int k;
    pins = PIN_RST;
    run = 1'h0;
    n_errors = 0;
    total_checks = 0;
    i_rst = 1'h1;
    repeat (6) @(negedge i_clock);
    i_rst = 1'h0;
    repeat (2) @(negedge i_clock);
    rdm(ADDR_CMD, FULL_MASK, CMD_RST);
    for (k = 0; k < 6; k++) begin
      pins.dcd_n = ROWS[k].dcd_n;
      pins.dsr_n = ROWS[k].dsr_n;
      bus(1'h1, ADDR_CMD, ROWS[k].cmd);
      chk({5'h00, rts_n, dtr_n, hf_n}, {5'h00, ROWS[k].pins_n});
      chk({7'h00, txd}, 8'h01);
      rdm(ADDR_SR_SYN, 8'hC0, {ROWS[k].st76, 6'h00});
    end
    bus(1'h1, ADDR_MODE, 8'h4D);
    run = 1'h1;
    bus(1'h1, ADDR_CMD, 8'h04);
    rdm(ADDR_SR_SYN, 8'hC0, 8'h40);
    pins.dsr_n = 1'h0;
    for (k = 0; k < 20 && te_n; k++) @(negedge i_clock);
    rdm(ADDR_SR_SYN, 8'h84, 8'h84);
    chk({7'h00, te_n}, 8'h01);
    line.send_char(8'h5A, 1'h1);
    for (k = 0; k < 100 && ra_n; k++) @(negedge i_clock);
    wt(ra_n === 1'h0);
    rdm(ADDR_DATA, FULL_MASK, 8'h5A);
    chk({7'h00, ra_n}, 8'h01);
    // unread char then a break frame: overrun plus framing
    line.send_char(8'hC3, 1'h1);
    line.send_char(8'h00, 1'h0);
    repeat (20) @(negedge i_clock);
    rdm(ADDR_SR_SYN, 8'h38, 8'h30);
    rdm(ADDR_DATA, FULL_MASK, 8'h00);
    bus(1'h1, ADDR_CMD, 8'h14);
    rdm(ADDR_SR_SYN, 8'h38, 8'h00);
    rdm(ADDR_CMD, FULL_MASK, 8'h04);
    pins.cts_n = 1'h0;
    bus(1'h1, ADDR_CMD, 8'h25);
    fork
      line.get_char(q2, ok);
      bus(1'h1, ADDR_DATA, 8'hA5);
    join
    wt(ok);
    chk(q2, 8'hA5);
    repeat (30) @(negedge i_clock);
    chk({6'h00, te_n, hf_n}, 8'h00);
    bus(1'h1, ADDR_CMD, 8'h2D);
    repeat (20) @(negedge i_clock);
    chk({7'h00, txd}, 8'h00);
    bus(1'h1, ADDR_CMD, 8'h25);
    repeat (40) @(negedge i_clock);
    // echo keeps the char for the processor, remote does not
    for (k = 1; k < 4; k += 2) begin
      bus(1'h1, ADDR_CMD, {k[1:0], 6'h04});
      fork
        line.get_char(q2, ok);
        line.send_char(8'h3C, 1'h1);
      join
      wt(ok);
      chk(q2, 8'h3C);
      chk({6'h00, ra_n, hf_n}, {6'h00, k[1], 1'h1});
    end
    bus(1'h1, ADDR_CMD, 8'hA7);
    bus(1'h0, ADDR_DATA, 8'h00);
    bus(1'h1, ADDR_DATA, 8'h96);
    for (k = 0; k < 200 && ra_n; k++) @(negedge i_clock);
    rdm(ADDR_DATA, FULL_MASK, 8'h96);
    chk({7'h00, txd}, 8'h01);
    // sync local loop: receiver hunts on the fill characters
    bus(1'h1, ADDR_CMD, 8'h00);
    bus(1'h1, ADDR_MODE, 8'h8C);
    bus(1'h1, ADDR_SR_SYN, 8'h16);
    bus(1'h1, ADDR_CMD, 8'hA7);
    repeat (300) @(negedge i_clock);
    rdm(ADDR_SR_SYN, 8'h21, 8'h21);
    chk({7'h00, te_n}, 8'h00);
    rdm(ADDR_DATA, FULL_MASK, 8'h16);
    stop_test();
  end
endmodule // uscl_core_bench
bind uscl_core uscl_core_checker u_chk (.i_clock, .i_rst, .i_enable, .i_ce_n, .i_rw, .o_data, .o_data_oe,
  .o_tx_data, .o_rts_n, .o_dtr_n, .o_tx_holding_free_n, .o_rx_char_available_n, .o_tx_idle_or_line_change_n);
`default_nettype wire

//--- uscl_core_checker.sv
// pin-level checks for the usart command/status block
`timescale 1ns/1ps
`default_nettype none
module uscl_core_checker (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_enable,
  input wire logic i_ce_n,
  input wire logic i_rw,
  input wire logic [uscl_pkg::DATA_W-1:0] o_data,
  input wire logic o_data_oe,
  input wire logic o_tx_data,
  input wire logic o_rts_n,
  input wire logic o_dtr_n,
  input wire logic o_tx_holding_free_n,
  input wire logic o_rx_char_available_n,
  input wire logic o_tx_idle_or_line_change_n
);
  import uscl_pkg::*;
  // cycles since chip enable was last low; bus side effects must land close to it
  logic [3:0] age_q;
  always_ff @(posedge i_clock) begin
    if (i_rst || !i_ce_n) begin
      age_q <= 4'h0;
    end else if (i_enable && age_q != 4'hF) begin
      age_q <= age_q + 4'h1;
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  chk_reset_levels: assert property ($fell(i_rst) |-> !o_data_oe && o_data == CHAR_RST && o_tx_data && o_rts_n
    && o_dtr_n && o_tx_holding_free_n && o_rx_char_available_n && o_tx_idle_or_line_change_n)
    else $error("outputs not at reset levels");
  chk_read_drives: assert property ($fell(i_ce_n) && !i_rw ##1 (!i_ce_n && !i_rw) [*4] |-> o_data_oe)
    else $error("read did not drive the data bus");
  chk_oe_bounded: assert property (o_data_oe |-> age_q <= 4'h6)
    else $error("data bus driven without a read");
  chk_data_moves: assert property ($changed(o_data) |-> age_q <= 4'h2)
    else $error("read data changed outside a read");
  chk_modem_cause: assert property ($changed(o_rts_n) || $changed(o_dtr_n) |-> age_q <= 4'h8)
    else $error("modem output moved without a command write");
  chk_rx_char_available_clear: assert property ($rose(o_rx_char_available_n) |-> age_q <= 4'h8)
    else $error("receive ready cleared without access");
  chk_tx_holding_free_load: assert property ($rose(o_tx_holding_free_n) |-> age_q <= 4'h8)
    else $error("transmit ready cleared without access");
  chk_empty_clear: assert property ($rose(o_tx_idle_or_line_change_n) |-> age_q <= 4'h8)
    else $error("empty or change flag cleared without access");
endmodule // uscl_core_checker
`default_nettype wire

//--- uscl_line_model.sv
// serial line side: bit clocks, async frame sender and frame capture
`timescale 1ns/1ps
`default_nettype none
module uscl_line_model (
  input wire logic i_run,
  input wire logic i_tx_data,
  output logic o_txc,
  output logic o_rxc,
  output var logic o_rxd
);
  logic bclk = 1'h1;
  // odd offset keeps bit clock edges unrelated to the system clock
  initial begin
    #7;
    forever #160 bclk = i_run ? ~bclk : 1'h1;
  end
  assign o_txc = bclk;
  assign o_rxc = bclk;
  initial o_rxd = 1'h1;
  task automatic send_char(input logic [7:0] ch, input logic stop);
    int i;
    @(negedge bclk) o_rxd = 1'h0;
    for (i = 0; i < 8; i++) @(negedge bclk) o_rxd = ch[i];
    @(negedge bclk) o_rxd = stop;
    @(negedge bclk) o_rxd = 1'h1;
  endtask
  // sample a whole bit after each launch edge, away from the output delay
  task automatic get_char(output logic [7:0] ch, output logic ok);
    int i;
    ok = 1'h0;
    ch = 8'h00;
    for (i = 0; i < 400 && !ok; i++) begin
      @(negedge bclk);
      ok = !i_tx_data;
    end
    for (i = 0; i < 8; i++) begin
      @(negedge bclk);
      ch[i] = i_tx_data;
    end
  endtask
endmodule // uscl_line_model
`default_nettype wire

//--- uscl_pkg.sv
// package: register map, field positions and pin carrier of the usart command/status block
`default_nettype none
package uscl_pkg;
  localparam int DATA_W = 8;
  localparam int PIN_W = 18;
  // register selects on the two address pins
  localparam logic [1:0] ADDR_DATA = 2'h0;
  localparam logic [1:0] ADDR_SR_SYN = 2'h1;
  localparam logic [1:0] ADDR_MODE = 2'h2;
  localparam logic [1:0] ADDR_CMD = 2'h3;
  // operating_submode codes
  localparam logic [1:0] SUB_NORMAL = 2'h0;
  localparam logic [1:0] SUB_ECHO = 2'h1;
  localparam logic [1:0] SUB_LOCAL = 2'h2;
  localparam logic [1:0] SUB_REMOTE = 2'h3;
  // command_control bits
  localparam int CR_TX_EN = 0;
  localparam int CR_DTR = 1;
  localparam int CR_RX_EN = 2;
  localparam int CR_BRK = 3;
  localparam int CR_ERR_CLR = 4;
  localparam int CR_RTS = 5;
  localparam int CR_SUB = 6;
  // mode bits
  localparam int MR_FMT = 0;
  localparam int MR_LEN = 2;
  localparam int MR_PAR_ON = 4;
  localparam int MR_PAR_EVEN = 5;
  localparam int MR_TRANSP = 6;
  localparam int MR_SINGLE = 7;
  // line_condition bits
  localparam int SR_TX_HOLDING_FREE = 0;
  localparam int SR_RX_CHAR_AVAILABLE = 1;
  localparam int SR_TXEMT = 2;
  localparam int SR_PAR = 3;
  localparam int SR_OVR = 4;
  localparam int SR_FRM = 5;
  localparam int SR_DCD = 6;
  localparam int SR_DSR = 7;
  // sync/escape character slots
  localparam logic [1:0] FIRST_SYNC_CHAR_IX = 2'h0;
  localparam logic [1:0] SYN2_IX = 2'h1;
  localparam logic [1:0] ESC_IX = 2'h2;
  localparam logic [7:0] CMD_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CHAR_RST = 8'h00;
  localparam logic [7:0] FULL_MASK = 8'hFF;
  localparam logic [3:0] CHAR_MIN = 4'h5;
  localparam logic [3:0] CHAR_MAX = 4'h8;
  // idle pin levels: strobes and modem inputs high
  localparam logic [17:0] PIN_RST = 18'h3003F;
  typedef struct packed {
    logic ce_n;
    logic rw;
    logic [1:0] addr;
    logic [7:0] data;
    logic tx_bit_clock;
    logic rx_bit_clock;
    logic rxd;
    logic cts_n;
    logic dcd_n;
    logic dsr_n;
  } uscl_pins_t;
  typedef enum logic [2:0] {RX_IDLE, RX_HUNT, RX_SYNC2, RX_DATA, RX_PAR, RX_STOP} uscl_rx_st_t;
  typedef enum logic [2:0] {TX_IDLE, TX_DATA, TX_PAR, TX_STOP, TX_BREAK} uscl_tx_st_t;
endpackage
`default_nettype wire
